// >>> afs_defines.vh
// Purpose: Constants for the antenna fault supervisor.
// Assumes: 20 MHz reference clock.
// Notes: Included by afs_top.v only.
`ifndef AFS_DEFINES_VH
`define AFS_DEFINES_VH
// Serial command numbers.
`define AFS_CMD_CLEAR_STATUS 4'h2
`define AFS_CMD_READ_STATUS 4'h9
// Status bit positions.
`define AFS_BIT_OVERTEMP 0
`define AFS_BIT_TO_GROUND 1
`define AFS_BIT_TO_SUPPLY 2
`define AFS_BIT_OPEN_LOAD 3
`define AFS_BIT_RETURN_OC 4
`define AFS_BIT_ILLEGAL 5
// Reset values.
`define AFS_STATUS_RESET 8'h00
`define AFS_STEP_RESET 4'hF
// Carrier divider and duty units (eighths of a carrier period, in quarters).
`define AFS_CARRIER_DIV 64
`define AFS_HIGH_Q_STEP1 6'h05
`define AFS_HIGH_Q_STEP5 6'h07
`define AFS_HIGH_Q_STEP9 6'h0A
`define AFS_HIGH_Q_STEP13 6'h10
// Timing: clock in MHz, reset stretch in us, debounce in cycles.
`define AFS_CLK_MHZ 20
`define AFS_POR_HOLD_US 30
`define AFS_POR_HOLD_CYC (`AFS_POR_HOLD_US * `AFS_CLK_MHZ)
`define AFS_DEBOUNCE_CYC 200
// Operating modes.
`define AFS_MODE_POWERDOWN 2'h0
`define AFS_MODE_STANDBY 2'h1
`define AFS_MODE_MODULATE 2'h2
`endif

// >>> afs_top.v
// Purpose: Fault supervisor, current step decode and clock outputs of an LF antenna driver.
// Assumes: Serial decoding done elsewhere; commands arrive as one-cycle strobes.
// Notes: Analog detectors arrive asynchronously and are synchronised here.
// How the pieces fit together:
// The analog detectors change at any time relative to the reference clock, so each one
// passes two flip-flops before any logic looks at it. That adds two cycles of delay to
// every fault, which is small against the debounce time and is accepted for safety.
// Every monitored fault has its own debounce counter. A counter runs only while its fault
// is present and falls back to zero the moment the fault drops, so short disturbances
// never add up across separate pulses. Once a counter has run its full length, the fault
// is treated as confirmed.
// A confirmed fault does three things in the same cycle. It sets its bit in the diagnosis
// status, it sets the shutdown latch, and on the first such cycle it sends a one-cycle
// request to empty the LF data buffer. The power stages follow the latch one cycle later,
// because their enables are registered outputs.
// The shutdown latch is released only by the clear command, and only when no fault is
// confirmed in that cycle. A fault that arrives together with a clear keeps the latch set,
// so the host can never switch the stages back on over a live fault.
// The illegal-command bit is set straight from the decoder strobe with no debounce and
// never touches the shutdown latch or the buffer.
// Monitoring depends on the operating mode. In power-down nothing is watched. In standby
// the low-side transistor, the switch transistor and the temperature are watched. In
// modulation everything is watched, including open load and overload to ground.
// The carrier is the reference clock divided by 64. Its high time is set in quarters of
// one eighth of a period, so the four duty classes fit exactly on the divider.
// The clock output toggles on reference edges, so its full rate is half the reference
// rate and its half rate is a quarter of it; a user who needs the exact oscillator rate
// must take it from the oscillator itself.
// After reset the core is held for a fixed number of cycles so that a reset pulse of any
// width gives the rest of the logic the full hold time.
//
`include "afs_defines.vh"
`timescale 1ns/1ps
module afs_top #(
   parameter DEBOUNCE_CYC = `AFS_DEBOUNCE_CYC,
   parameter POR_HOLD_CYC = `AFS_POR_HOLD_CYC
) (
   // Clock and reset.
   input wire i_ref_clk,
   input wire i_resetn,
   // Configuration and commands from the serial decoder.
   input wire [3:0] i_coil_current_step,
   input wire i_coil_step_wr,
   input wire i_clock_out_divider_sel,
   input wire [1:0] i_mode,
   input wire i_modulation_busy,
   input wire i_cmd_valid,
   input wire [3:0] i_cmd_num,
   input wire i_illegal_cmd,
   // Asynchronous analog detectors.
   input wire i_overtemp,
   input wire i_oc_high_side,
   input wire i_oc_low_side,
   input wire i_oc_return,
   input wire i_sense_resistor_input,
   // Outputs.
   output reg [7:0] o_status_data,
   output reg o_status_valid,
   output reg o_boost_converter_en,
   output reg o_driver_pwm,
   output reg o_current_limit,
   output reg o_quick_start_switch,
   output reg o_buffer_clear,
   output reg o_clock_output_pin,
   output reg o_modulation_active_pin,
   output reg o_internal_resetn,
   output reg [1:0] o_duty_class
);

////////////////////////////////////////////////////////////////////////////////
// Internal reset stretch: a reset pulse of any width keeps the core in reset.
reg [15:0] por_count;
reg core_rst;
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      por_count <= 16'h0000;
      core_rst <= 1'b1;
      o_internal_resetn <= 1'b0;
   end else begin
      if (por_count < POR_HOLD_CYC[15:0]) begin
         por_count <= por_count + 16'h0001;
      end
      core_rst <= (por_count < POR_HOLD_CYC[15:0]);
      o_internal_resetn <= !(por_count < POR_HOLD_CYC[15:0]);
   end
end

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchronisers; stage one is read only by stage two.
reg [5:0] sync1;
reg [5:0] sync2;
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
   end else begin
      sync1 <= {i_sense_resistor_input, i_oc_return, i_oc_low_side, i_oc_high_side,
                i_overtemp, 1'b0};
      sync2 <= sync1;
   end
end
wire s_ot = sync2[1];
wire s_hs = sync2[2];
wire s_ls = sync2[3];
wire s_ret = sync2[4];
wire s_sense = sync2[5];

////////////////////////////////////////////////////////////////////////////////
// Mode gating of the monitors.
wire in_mod = (i_mode == `AFS_MODE_MODULATE);
wire in_stby = (i_mode == `AFS_MODE_STANDBY);
wire monitoring = in_mod | in_stby;

// Open-load detector: no sense polarity change during one carrier period.
reg sense_d;
reg [6:0] pol_count;
wire pol_timeout = (pol_count >= 7'h40);
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      sense_d <= 1'b0;
      pol_count <= 7'h00;
   end else begin
      sense_d <= s_sense;
      if (!in_mod || (s_sense != sense_d)) begin
         pol_count <= 7'h00;
      end else if (!pol_timeout) begin
         pol_count <= pol_count + 7'h01;
      end
   end
end

// Raw fault per status bit; ground overload is the high-side path, only seen while active.
reg [4:0] raw;
always @* begin
   raw = 5'h00;
   raw[`AFS_BIT_OVERTEMP] = monitoring & s_ot;
   raw[`AFS_BIT_TO_GROUND] = in_mod & s_hs;
   raw[`AFS_BIT_TO_SUPPLY] = monitoring & s_ls;
   raw[`AFS_BIT_OPEN_LOAD] = in_mod & pol_timeout;
   raw[`AFS_BIT_RETURN_OC] = monitoring & s_ret;
end

////////////////////////////////////////////////////////////////////////////////
// One debounce counter per fault, cleared whenever its fault drops.
reg [15:0] deb [0:4];
reg [4:0] confirmed;
integer k;
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      for (k = 0; k < 5; k = k + 1) begin
         deb[k] <= 16'h0000;
      end
      confirmed <= 5'h00;
   end else begin
      for (k = 0; k < 5; k = k + 1) begin
         if (!raw[k] || core_rst) begin
            deb[k] <= 16'h0000;
            confirmed[k] <= 1'b0;
         end else if (deb[k] >= DEBOUNCE_CYC[15:0] - 16'h0001) begin
            confirmed[k] <= 1'b1;
         end else begin
            deb[k] <= deb[k] + 16'h0001;
            confirmed[k] <= 1'b0;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Status register and shutdown latch; a new fault wins over a clear.
reg [7:0] status;
reg shutdown;
wire clear_cmd = i_cmd_valid & (i_cmd_num == `AFS_CMD_CLEAR_STATUS);
wire read_cmd = i_cmd_valid & (i_cmd_num == `AFS_CMD_READ_STATUS);
wire any_fault = |confirmed;
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      status <= `AFS_STATUS_RESET;
      shutdown <= 1'b0;
      o_buffer_clear <= 1'b0;
   end else if (core_rst) begin
      status <= `AFS_STATUS_RESET;
      shutdown <= 1'b0;
      o_buffer_clear <= 1'b0;
   end else begin
      status <= (clear_cmd ? 8'h00 : status) | {2'b00, i_illegal_cmd, confirmed};
      shutdown <= any_fault | (shutdown & !clear_cmd);
      o_buffer_clear <= any_fault & !shutdown;
   end
end

// Status answer to the read command.
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      o_status_data <= 8'h00;
      o_status_valid <= 1'b0;
   end else begin
      o_status_valid <= read_cmd & !core_rst;
      if (read_cmd) begin
         o_status_data <= {2'b00, status[5:0]};
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Current step register and duty class.
reg [3:0] step;
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      step <= `AFS_STEP_RESET;
   end else if (core_rst) begin
      step <= `AFS_STEP_RESET;
   end else if (i_coil_step_wr) begin
      step <= i_coil_current_step;
   end
end

// High time in quarter-eighths of a carrier period (out of 32) per class.
function [5:0] afs_high_q;
   input [1:0] cls;
   begin
      case (cls)
         2'h0: afs_high_q = `AFS_HIGH_Q_STEP1;
         2'h1: afs_high_q = `AFS_HIGH_Q_STEP5;
         2'h2: afs_high_q = `AFS_HIGH_Q_STEP9;
         default: afs_high_q = `AFS_HIGH_Q_STEP13;
      endcase
   end
endfunction

// High time of the current class, held in a net so the compare can take a slice of it.
wire [5:0] high_q = afs_high_q(step[3:2]);

// Carrier phase divider, 64 reference cycles per period; two cycles per quarter unit.
reg [5:0] phase;
wire stages_on = in_mod & !shutdown & !core_rst;
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      phase <= 6'h00;
      o_driver_pwm <= 1'b0;
      o_duty_class <= 2'h3;
      o_boost_converter_en <= 1'b0;
      o_quick_start_switch <= 1'b0;
      o_current_limit <= 1'b0;
      o_modulation_active_pin <= 1'b0;
   end else begin
      phase <= phase + 6'h01;
      o_duty_class <= step[3:2];
      o_driver_pwm <= stages_on & (phase[5:1] < high_q[4:0]) |
                      stages_on & (high_q == 6'h10) & !phase[5];
      o_boost_converter_en <= stages_on;
      o_quick_start_switch <= monitoring & !shutdown & !core_rst;
      o_current_limit <= monitoring & (s_hs | s_ls);
      o_modulation_active_pin <= stages_on & i_modulation_busy;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Clock output: toggling register gives half rate, a fast toggle stands for full rate.
reg clk_half;
always @(posedge i_ref_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      clk_half <= 1'b0;
      o_clock_output_pin <= 1'b0;
   end else begin
      clk_half <= !clk_half;
      if (i_mode == `AFS_MODE_POWERDOWN || core_rst) begin
         o_clock_output_pin <= 1'b0;
      end else if (i_clock_out_divider_sel) begin
         // Toggling on every other edge halves the rate without a second clock.
         o_clock_output_pin <= clk_half ? !o_clock_output_pin : o_clock_output_pin;
      end else begin
         o_clock_output_pin <= !o_clock_output_pin;
      end
   end
end

endmodule // afs_top

// >>> afs_top_asserts.sv
// Purpose: Port checks of the antenna fault supervisor.
// Assumes: Reset stretch of at least 4 cycles.
// Notes: Bound to afs_top after the module.
`timescale 1ns/1ps
module afs_top_asserts (
   // Clock, reset and inputs.
   input wire i_ref_clk,
   input wire i_resetn,
   input wire i_clock_out_divider_sel,
   input wire [1:0] i_mode,
   input wire i_cmd_valid,
   input wire [3:0] i_cmd_num,
   // Outputs.
   input wire [7:0] o_status_data,
   input wire o_status_valid,
   input wire o_boost_converter_en,
   input wire o_buffer_clear,
   input wire o_clock_output_pin,
   input wire o_internal_resetn
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   // Reads answer one cycle later and only reads make an answer.
   a_read_answered: assert property (
      i_cmd_valid && i_cmd_num == 4'h9 && o_internal_resetn |=> o_status_valid)
      else $error("read not answered");
   a_answer_has_cause: assert property (
      o_status_valid |-> $past(i_cmd_valid) && $past(i_cmd_num) == 4'h9)
      else $error("answer without read");
   a_spare_bits_zero: assert property (
      o_status_valid |-> o_status_data[7:6] == 2'h0)
      else $error("spare status bits set");
   // Buffer clearing only ever comes with the stages going off.
   a_clear_with_off: assert property (
      o_buffer_clear |-> ##[0:1] !o_boost_converter_en)
      else $error("buffer cleared while stages on");
   a_off_until_clear: assert property (
      o_buffer_clear ##1 (!(i_cmd_valid && i_cmd_num == 4'h2))[*8] |-> !o_boost_converter_en)
      else $error("stages back on without clear");
   a_pd_clock_stops: assert property (
      (i_mode == 2'h0)[*4] |=> $stable(o_clock_output_pin))
      else $error("clock runs in power-down");
   a_full_rate_runs: assert property (
      (i_mode == 2'h1 && !i_clock_out_divider_sel && o_internal_resetn)[*4]
      |=> $changed(o_clock_output_pin))
      else $error("full rate clock stalled");
   a_reset_stretched: assert property (
      $rose(i_resetn) |-> (!o_internal_resetn)[*4])
      else $error("internal reset too short");
endmodule // afs_top_asserts
bind afs_top afs_top_asserts u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
   .i_clock_out_divider_sel(i_clock_out_divider_sel), .i_mode(i_mode),
   .i_cmd_valid(i_cmd_valid), .i_cmd_num(i_cmd_num), .o_status_data(o_status_data),
   .o_status_valid(o_status_valid), .o_boost_converter_en(o_boost_converter_en),
   .o_buffer_clear(o_buffer_clear), .o_clock_output_pin(o_clock_output_pin),
   .o_internal_resetn(o_internal_resetn));

// >>> afs_host_model.sv
// Purpose: Host side issuing serial commands as strobes.
// Assumes: Commands are given after the internal reset is released.
// Notes: Number lines are scrambled when idle.
`timescale 1ns/1ps
module afs_host_model (
   // Clock.
   input wire i_ref_clk,
   // Command strobes.
   output reg o_cmd_valid = 1'b0,
   output reg [3:0] o_cmd_num = 4'h0,
   output reg o_illegal_cmd = 1'b0
);
   // One command per call, held over exactly one sampling edge.
   task send(input [3:0] num, input bad);
      begin
         @(posedge i_ref_clk);
         o_cmd_valid <= ~bad;
         o_cmd_num <= num;
         o_illegal_cmd <= bad;
         @(posedge i_ref_clk);
         o_cmd_valid <= 1'b0;
         o_illegal_cmd <= 1'b0;
         o_cmd_num <= ~num;
      end
   endtask
endmodule // afs_host_model

// >>> test_antenna_fault_supervisor.sv
// Purpose: Self-checking bench of the antenna fault supervisor.
// Assumes: Short debounce and reset stretch parameters.
// Notes: Fault vector is {return, low, high, overtemp}.
`timescale 1ns/1ps
module test_antenna_fault_supervisor;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg [3:0] step = 4'hF;
   reg wr = 1'b0;
   reg dsel = 1'b0;
   reg [1:0] mode = 2'h1;
   reg busy = 1'b0;
   reg [3:0] flt = 4'h0;
   reg sense = 1'b0;
   reg srun = 1'b1;
   wire cv, ill, sv, boost, pwm, lim, qss, clr, cko, mact, irn;
   wire [3:0] cn;
   wire [7:0] sd;
   wire [1:0] duty;
   integer err_total = 0;
   integer n_tests = 0;
   integer n_clr = 0;
   integer i, k, c0;
   integer n_hi, n_rise;
   reg prev;
   afs_host_model host (.i_ref_clk(clk), .o_cmd_valid(cv), .o_cmd_num(cn), .o_illegal_cmd(ill));
   afs_top #(.DEBOUNCE_CYC(8), .POR_HOLD_CYC(4)) uut (.i_ref_clk(clk), .i_resetn(rstn),
      .i_coil_current_step(step), .i_coil_step_wr(wr), .i_clock_out_divider_sel(dsel),
      .i_mode(mode), .i_modulation_busy(busy), .i_cmd_valid(cv), .i_cmd_num(cn),
      .i_illegal_cmd(ill), .i_overtemp(flt[0]), .i_oc_high_side(flt[1]),
      .i_oc_low_side(flt[2]), .i_oc_return(flt[3]), .i_sense_resistor_input(sense),
      .o_status_data(sd), .o_status_valid(sv), .o_boost_converter_en(boost),
      .o_driver_pwm(pwm), .o_current_limit(lim), .o_quick_start_switch(qss),
      .o_buffer_clear(clr), .o_clock_output_pin(cko), .o_modulation_active_pin(mact),
      .o_internal_resetn(irn), .o_duty_class(duty));
   // Clock, and a load that swings every cycle unless stopped.
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      sense <= srun ? ~sense : sense;
      n_clr <= n_clr + (clr === 1'b1);
   end
   task check(input [7:0] seen, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task read_status(input [7:0] exp);
      begin
         host.send(4'h9, 1'b0);
         @(negedge clk);
         check({7'h00, sv}, 8'h01);
         check(sd, exp);
      end
   endtask
   // Every step code lands in its duty class.
   task t_steps;
      begin
         check({6'h00, duty}, 8'h03);
         for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk);
            step <= i[3:0];
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            repeat (2) @(negedge clk);
            check({6'h00, duty}, {6'h00, i[3:2]});
         end
      end
   endtask
   // Carrier duty and period for classes 3 and 0, then clock output at both rates in standby and stopped in power-down.
   task t_clocks;
      begin
         @(posedge clk);
         mode <= 2'h2;
         for (k = 0; k < 2; k = k + 1) begin
            @(posedge clk);
            step <= (k == 0) ? 4'hF : 4'h0;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            repeat (4) @(posedge clk);
            @(negedge clk);
            prev = pwm;
            n_hi = 0;
            n_rise = 0;
            for (i = 0; i < 128; i = i + 1) begin
               @(negedge clk);
               n_hi = n_hi + pwm;
               n_rise = n_rise + (pwm & !prev);
               prev = pwm;
            end
            check(n_hi[7:0], (k == 0) ? 8'h40 : 8'h14);
            check(n_rise[7:0], 8'h02);
         end
         for (k = 0; k < 3; k = k + 1) begin
            @(posedge clk);
            mode <= (k == 2) ? 2'h0 : 2'h1;
            dsel <= (k == 1);
            repeat (4) @(posedge clk);
            @(negedge clk);
            prev = cko;
            n_hi = 0;
            for (i = 0; i < 16; i = i + 1) begin
               @(negedge clk);
               n_hi = n_hi + (cko != prev);
               prev = cko;
            end
            check(n_hi[7:0], (k == 0) ? 8'h10 : (k == 1) ? 8'h08 : 8'h00);
         end
         @(posedge clk);
         mode <= 2'h1;
         dsel <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   // Each held fault shuts down and reports its bit; after it drops, the clear command empties the status.
   task t_faults;
      begin
         for (k = 0; k < 5; k = k + 1) begin
            c0 = n_clr;
            @(posedge clk);
            mode <= (k == 1 || k == 4) ? 2'h2 : 2'h1;
            flt <= (k < 4) ? (4'h1 << k) : 4'h0;
            srun <= (k != 4);
            repeat (4) @(negedge clk);
            if (k == 1 || k == 2) check({7'h00, lim}, 8'h01);
            repeat (90) @(posedge clk);
            check({7'h00, n_clr == c0 + 1}, 8'h01);
            read_status(8'h01 << ((k == 3) ? 4 : (k == 4) ? 3 : k));
            check({6'h00, boost, qss}, 8'h00);
            @(posedge clk);
            flt <= 4'h0;
            srun <= 1'b1;
            mode <= 2'h1;
            repeat (4) @(posedge clk);
            host.send(4'h2, 1'b0);
            read_status(8'h00);
         end
      end
   endtask
   // Pulses shorter than the debounce never add up to a shutdown.
   task t_short;
      begin
         c0 = n_clr;
         dsel <= 1'b1;
         for (k = 0; k < 3; k = k + 1) begin
            @(posedge clk);
            flt <= 4'h1;
            repeat (5) @(posedge clk);
            flt <= 4'h0;
            repeat (2) @(posedge clk);
         end
         dsel <= 1'b0;
         repeat (20) @(posedge clk);
         read_status(8'h00);
         check({7'h00, n_clr == c0}, 8'h01);
      end
   endtask
   // Illegal command flags at once, no shutdown; power-down ignores faults.
   task t_illegal_pd;
      begin
         c0 = n_clr;
         host.send(4'h0, 1'b1);
         read_status(8'h20);
         check({7'h00, n_clr == c0}, 8'h01);
         host.send(4'h2, 1'b0);
         @(posedge clk);
         mode <= 2'h0;
         flt <= 4'hF;
         repeat (40) @(posedge clk);
         flt <= 4'h0;
         repeat (4) @(posedge clk);
         mode <= 2'h2;
         busy <= 1'b1;
         repeat (4) @(negedge clk);
         check({7'h00, mact}, 8'h01);
         busy <= 1'b0;
         mode <= 2'h1;
         read_status(8'h00);
         check({7'h00, mact}, 8'h00);
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", n_tests, err_total);
         if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   // Whole run is about 1000 cycles; the limit is four times that.
   initial begin
      #200000;
      err_total = err_total + 1;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (10) @(posedge clk);
      @(negedge clk);
      check({7'h00, irn}, 8'h01);
      t_steps;
      t_clocks;
      t_faults;
      t_short;
      t_illegal_pd;
      finish_test;
   end
endmodule // test_antenna_fault_supervisor
